// File: hdl/return_and_rotate_instr_exec.sv
`timescale 1ns/1ps

// Contract
// [RL1] Return-with-literal (11 01xx kkkk kkkk) loads the 8-bit literal into W.
// [RL2] Return-with-literal loads the program counter from the stack top entry.
// [RL3] Return-with-literal is one word, two cycles, status flags unchanged.
// [RL4] Subroutine exit (00 0000 0000 1000) pops stack into PC, flags untouched.
// [RL5] Subroutine exit is one word and completes in two cycles.
// [RL6] Rotate-left-through-carry shifts file byte left with carry as ninth bit.
// [RL7] Rotate takes 7-bit address; d=0 writes W, d=1 writes register back.
// [RL8] Rotate modifies only carry and completes in one cycle.
// [RL9] Rotate moves old bit 7 into carry and old carry into bit 0.
module return_and_rotate_instr_exec
    import ret_rot_pkg::*;
(
    input  wire logic                mclk_in,
    input  wire logic                rst_b_in,
    input  wire logic                instr_valid_in,
    input  wire logic [INSTR_W-1:0]  instr_in,
    input  wire logic [PC_W-1:0]     stack_top_in,
    input  wire logic [DATA_W-1:0]   file_rdata_in,
    input  wire logic                carry_in,
    output logic                     busy_out,
    output logic                     done_out,
    output logic                     stack_pop_out,
    output logic                     pc_load_out,
    output logic [PC_W-1:0]          pc_value_out,
    output logic [ADDR_W-1:0]        file_addr_out,
    output logic                     file_we_out,
    output logic [DATA_W-1:0]        file_wdata_out,
    output logic                     carry_we_out,
    output logic                     carry_out,
    output logic                     w_we_out,
    output logic [DATA_W-1:0]        w_out
);

    // ==========================================================
    // State
    // ==========================================================
    typedef enum logic [0:0] {IDLE, RET_SECOND} phase_type;

    typedef struct packed {
        phase_type          phase;
        logic               done;
        logic               pop;
        logic               pc_load;
        logic [PC_W-1:0]    pc_value;
        logic               file_we;
        logic [DATA_W-1:0]  file_wdata;
        logic               carry_we;
        logic               carry;
        logic               w_we;
        logic [DATA_W-1:0]  w;
    } state_type;

    state_type state_r;
    state_type state_nxt;

    localparam state_type STATE_RESET = '{
        phase:      IDLE,
        done:       1'b0,
        pop:        1'b0,
        pc_load:    1'b0,
        pc_value:   PC_RESET,
        file_we:    1'b0,
        file_wdata: W_RESET,
        carry_we:   1'b0,
        carry:      1'b0,
        w_we:       1'b0,
        w:          W_RESET
    };

    // ==========================================================
    // Instruction fields
    // ==========================================================
    logic [3:0]         top4_field;
    logic [5:0]         top6_field;
    logic [DATA_W-1:0]  literal_field;
    logic               dest_field;
    logic [ADDR_W-1:0]  file_field;

    assign top4_field    = instr_in[INSTR_W-1:INSTR_W-4];
    assign top6_field    = instr_in[INSTR_W-1:INSTR_W-6];
    assign literal_field = instr_in[DATA_W-1:0];
    assign dest_field    = instr_in[DEST_BIT];
    assign file_field    = instr_in[ADDR_W-1:0];

    // ==========================================================
    // Decode
    // ==========================================================
    typedef enum logic [1:0] {CMD_NONE, CMD_RETLIT, CMD_SUBEXIT, CMD_ROTL} cmd_type;

    logic    is_retlit;
    logic    is_subexit;
    logic    is_rotl;
    cmd_type cmd;

    assign is_retlit  = top4_field == RETLIT_TOP;
    assign is_subexit = instr_in == SUBEXIT_CODE;
    assign is_rotl    = top6_field == ROTL_TOP;

    // Fixed priority; the opcode patterns never overlap
    always_comb
    begin
        cmd = CMD_NONE;
        if (instr_valid_in)
        begin
            if (is_retlit)
            begin
                cmd = CMD_RETLIT;
            end
            else if (is_subexit)
            begin
                cmd = CMD_SUBEXIT;
            end
            else if (is_rotl)
            begin
                cmd = CMD_ROTL;
            end
        end
    end

    // ==========================================================
    // Rotate datapath
    // ==========================================================
    logic [DATA_W:0]    rot_wide;
    logic [DATA_W-1:0]  rot_result;
    logic               rot_carry;

    assign rot_wide   = {file_rdata_in, carry_in};                  // RL6 RL9
    assign rot_result = rot_wide[DATA_W-1:0];                       // RL6
    assign rot_carry  = rot_wide[DATA_W];                           // RL9

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb
    begin
        state_nxt          = state_r;
        state_nxt.done     = 1'b0;
        state_nxt.pop      = 1'b0;
        state_nxt.pc_load  = 1'b0;
        state_nxt.file_we  = 1'b0;
        state_nxt.carry_we = 1'b0;
        state_nxt.w_we     = 1'b0;
        unique case (state_r.phase)
            IDLE:
            begin
                unique case (cmd)
                    CMD_RETLIT:
                    begin
                        state_nxt.w        = literal_field;         // RL1
                        state_nxt.w_we     = 1'b1;                  // RL1
                        state_nxt.pc_value = stack_top_in;          // RL2
                        state_nxt.pc_load  = 1'b1;                  // RL2
                        state_nxt.pop      = 1'b1;                  // RL2
                        state_nxt.phase    = RET_SECOND;            // RL3
                    end
                    CMD_SUBEXIT:
                    begin
                        state_nxt.pc_value = stack_top_in;          // RL4
                        state_nxt.pc_load  = 1'b1;                  // RL4
                        state_nxt.pop      = 1'b1;                  // RL4
                        state_nxt.phase    = RET_SECOND;            // RL5
                    end
                    CMD_ROTL:
                    begin
                        state_nxt.carry    = rot_carry;             // RL9
                        state_nxt.carry_we = 1'b1;                  // RL8
                        state_nxt.done     = 1'b1;                  // RL8
                        if (dest_field == DEST_FILE)                // RL7
                        begin
                            state_nxt.file_wdata = rot_result;
                            state_nxt.file_we    = 1'b1;
                        end
                        else
                        begin
                            state_nxt.w    = rot_result;
                            state_nxt.w_we = 1'b1;
                        end
                    end
                    CMD_NONE:
                    begin
                        state_nxt.phase = IDLE;
                    end
                endcase
            end
            RET_SECOND:
            begin
                // Second cycle flushes the fetched word; no flag touched
                state_nxt.done  = 1'b1;                             // RL3 RL5
                state_nxt.phase = IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state_r <= STATE_RESET;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign busy_out       = state_r.phase == RET_SECOND;
    assign done_out       = state_r.done;
    assign stack_pop_out  = state_r.pop;
    assign pc_load_out    = state_r.pc_load;
    assign pc_value_out   = state_r.pc_value;
    assign file_addr_out  = file_field;                            // RL7
    assign file_we_out    = state_r.file_we;
    assign file_wdata_out = state_r.file_wdata;
    assign carry_we_out   = state_r.carry_we;                      // RL8
    assign carry_out      = state_r.carry;
    assign w_we_out       = state_r.w_we;
    assign w_out          = state_r.w;

endmodule

// File: include/ret_rot_pkg.sv
package ret_rot_pkg;

    // ==========================================================
    // Instruction word layout
    // ==========================================================
    localparam int INSTR_W          = 14;
    localparam int DATA_W           = 8;
    localparam int ADDR_W           = 7;
    localparam int PC_W             = 13;
    localparam int DEST_BIT         = 7;
    localparam int CARRY_BIT        = 0;

    // Opcode patterns
    localparam logic [3:0]  RETLIT_TOP      = 4'hD;          // 11 01xx
    localparam logic [13:0] SUBEXIT_CODE    = 14'h0008;      // 00 0000 0000 1000
    localparam logic [5:0]  ROTL_TOP        = 6'h0D;         // 00 1101

    // Destination select values
    localparam logic        DEST_WREG       = 1'h0;
    localparam logic        DEST_FILE       = 1'h1;

    // Cycle counts per instruction
    localparam int RET_CYCLES       = 2;
    localparam int ROT_CYCLES       = 1;

    // Reset values
    localparam logic [7:0]  W_RESET         = 8'h00;
    localparam logic [12:0] PC_RESET        = 13'h0000;

endpackage

// File: dv/ret_rot_chk.sv
`timescale 1ns/1ps
module ret_rot_chk
    import ret_rot_pkg::*;
(
    input wire logic                mclk_in,
    input wire logic                rst_b_in,
    input wire logic                instr_valid_in,
    input wire logic                carry_in,
    input wire logic                busy_out,
    input wire logic                done_out,
    input wire logic                stack_pop_out,
    input wire logic                pc_load_out,
    input wire logic                file_we_out,
    input wire logic                carry_we_out,
    input wire logic                carry_out,
    input wire logic                w_we_out,
    input wire logic [INSTR_W-1:0]  instr_in,
    input wire logic [PC_W-1:0]     stack_top_in,
    input wire logic [PC_W-1:0]     pc_value_out,
    input wire logic [DATA_W-1:0]   file_rdata_in,
    input wire logic [DATA_W-1:0]   file_wdata_out,
    input wire logic [DATA_W-1:0]   w_out,
    input wire logic [ADDR_W-1:0]   file_addr_out
);
    // ==========================================================
    // Decoded requests taken at an edge
    // ==========================================================
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);
    wire tk = instr_valid_in && !busy_out;
    wire rl = tk && instr_in[13:10] == RETLIT_TOP;
    wire rx = tk && instr_in == SUBEXIT_CODE;
    wire ro = tk && instr_in[13:8] == ROTL_TOP;
    lit_w_load_a: assert property (rl |=> w_we_out && w_out == $past(instr_in[7:0]))
        else $error("literal not loaded into w");
    ret_pc_load_a: assert property (rl || rx |=> pc_load_out && stack_pop_out && pc_value_out == $past(stack_top_in))
        else $error("return did not load pc from stack top");
    exit_no_w_a: assert property (rx |=> !w_we_out)
        else $error("subroutine exit wrote w");
    ret_two_cycle_a: assert property (rl || rx |=> busy_out && !done_out ##1 done_out && !busy_out)
        else $error("return not two cycles");
    ret_flags_kept_a: assert property (rl || rx |=> !carry_we_out [*2])
        else $error("return touched carry");
    rot_carry_a: assert property (ro |=> carry_we_out && done_out && carry_out == $past(file_rdata_in[7]))
        else $error("rotate carry wrong");
    rot_to_w_a: assert property (ro && !instr_in[DEST_BIT] |=> w_we_out && !file_we_out && w_out == {$past(file_rdata_in[6:0]), $past(carry_in)})
        else $error("rotate to w wrong");
    rot_to_file_a: assert property (ro && instr_in[DEST_BIT] |=> file_we_out && !w_we_out && file_wdata_out == {$past(file_rdata_in[6:0]), $past(carry_in)})
        else $error("rotate to file wrong");
    file_addr_a: assert property (file_addr_out == instr_in[6:0])
        else $error("file address wrong");
    rot_one_cycle_a: assert property (ro |=> !busy_out && !stack_pop_out && !pc_load_out)
        else $error("rotate not single cycle");
    cover property (rl);
    cover property (rx);
    cover property (ro && instr_in[DEST_BIT]);
    cover property (ro && !instr_in[DEST_BIT]);
endmodule
bind return_and_rotate_instr_exec ret_rot_chk ret_rot_chk_i (.*);

// File: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
    import ret_rot_pkg::*;
    logic mclk_in = 0, rst_b_in = 0, instr_valid_in = 0, carry_in = 0;
    logic [INSTR_W-1:0] instr_in = '0;
    logic [PC_W-1:0] stack_top_in = '0;
    logic [DATA_W-1:0] file_rdata_in = '0;
    logic busy_out, done_out, stack_pop_out, pc_load_out, file_we_out, carry_we_out, carry_out, w_we_out;
    logic [PC_W-1:0] pc_value_out;
    logic [ADDR_W-1:0] file_addr_out;
    logic [DATA_W-1:0] file_wdata_out, w_out;
    int fails = 0, tests_run = 0;
    logic [31:0] seed = 32'hEAC43637;
    wire [6:0] pv = {busy_out, done_out, stack_pop_out, pc_load_out, file_we_out, carry_we_out, w_we_out};
    return_and_rotate_instr_exec return_and_rotate_instr_exec_i (.*);
    // ==========================================================
    // Expectations and checks
    // ==========================================================
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [6:0] pulses(logic [13:0] i);
        if (i[13:10] == RETLIT_TOP) return 7'h59;
        if (i == SUBEXIT_CODE) return 7'h58;
        if (i[13:8] == ROTL_TOP) return i[DEST_BIT] ? 7'h26 : 7'h23;
        return 7'h00;
    endfunction
    task automatic chk(string n, logic [12:0] e, logic [12:0] g);
        tests_run++;
        if (g !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic report_and_stop;
        if (fails == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Called at a falling edge; leaves valid up so rotates run back to back
    task automatic run(logic [13:0] i);
        logic [8:0] r;
        logic [6:0] e;
        seed = lfsr(seed);
        instr_valid_in = 1;
        instr_in = i;
        {carry_in, file_rdata_in, stack_top_in} = seed[21:0];
        r = {file_rdata_in, carry_in};
        e = pulses(i);
        @(negedge mclk_in);
        chk("addr", i[6:0], file_addr_out);
        chk("pulses", e, pv);
        if (e[3]) chk("pc", stack_top_in, pc_value_out);
        if (e == 7'h59) chk("w", i[7:0], w_out);
        if (e[1]) chk("carry", r[8], carry_out);
        if (e == 7'h23) chk("w", r[7:0], w_out);
        if (e == 7'h26) chk("wdata", r[7:0], file_wdata_out);
        if (e[3])
        begin
            instr_in = {ROTL_TOP, seed[7:0]};
            @(negedge mclk_in);
            chk("pulses", 7'h20, pv);
        end
    endtask
    initial forever #4 mclk_in = ~mclk_in;
    initial
    begin
        #20000;
        fails++;
        report_and_stop;
    end
    initial
    begin
        repeat (4) @(negedge mclk_in);
        rst_b_in = 1;
        run(14'h3400);
        run(14'h37FF);
        run(SUBEXIT_CODE);
        run(14'h0DFF);
        run(14'h0D00);
        run(14'h0009);
        repeat (300)
        begin
            seed = lfsr(seed);
            run(seed[1] ? (seed[0] ? {RETLIT_TOP, seed[11:2]} : SUBEXIT_CODE) : (seed[0] ? {ROTL_TOP, seed[9:2]} : seed[15:2]));
        end
        instr_valid_in = 0;
        report_and_stop;
    end
endmodule
